// ---- inc/shso_pkg.sv ----
// shared constants of the sensor hub status object bank
package shso_pkg;
    localparam int NUM_UNITS = 30;
    localparam logic [15:0] OBJ_DUMMY = 16'h3004;
    localparam logic [15:0] OBJ_DELAY = 16'h3005;
    localparam logic [15:0] OBJ_LINK = 16'h300A;
    localparam logic [15:0] OBJ_WARN = 16'h300B;
    localparam logic [15:0] OBJ_MAP = 16'h300C;
    localparam logic [15:0] OBJ_RESET = 16'h3010;
    localparam logic [15:0] OBJ_INBITS = 16'h3020;
    localparam logic [7:0] SUB_ONE = 8'h01;
    localparam logic [7:0] SUB_TWO = 8'h02;
    localparam logic [7:0] SUB_THREE = 8'h03;
    localparam logic [7:0] SUB_INBIT_LAST = 8'h40;
    localparam logic [7:0] INBITS_COUNT = 8'h40;
    localparam logic [31:0] DUMMY_MASK_LEGAL = 32'h3FFFFFFF;
    localparam logic [31:0] DUMMY_MASK_RST = 32'h00000000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] RESET_CMD = 16'h0001;
    localparam logic [15:0] RESET_READ = 16'h0000;
    localparam int LINK_BUSY_BIT = 0;
    localparam int LINK_MISMATCH_BIT = 1;
    localparam int WARN_LO = 8;
    localparam int WARN_HI = 15;
    localparam int STATUS_W = 16;
    // input delay status codes
    localparam logic [7:0] DELAY_UNDEF = 8'h00;
    localparam logic [7:0] DELAY_STD = 8'h01;
    localparam logic [7:0] DELAY_HIGH = 8'h02;
    localparam logic [7:0] DELAY_LOW1 = 8'h03;
    localparam logic [7:0] DELAY_LOW2 = 8'h04;
    localparam logic [7:0] DELAY_NORMAL_MAP = 8'h05;
    // free-run speed selections
    localparam logic [1:0] SPEED_STD = 2'h0;
    localparam logic [1:0] SPEED_HIGH = 2'h1;
    localparam logic [1:0] SPEED_LOW1 = 2'h2;
    localparam logic [1:0] SPEED_LOW2 = 2'h3;
    // transmit mapping modes and their size limits in bytes
    localparam logic [7:0] MAP_NORMAL = 8'h00;
    localparam logic [7:0] MAP_FAST = 8'h01;
    localparam logic [9:0] MAP_NORMAL_MAX = 10'h15E;
    localparam logic [9:0] MAP_FAST_MAX = 10'h06C;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK = 2'b10
    } shso_state_e;
endpackage : shso_pkg

// ---- src/shso_warn.sv ----
// per-unit warning flags derived from sensor status words
`timescale 1ns/1ps
module shso_warn (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [shso_pkg::NUM_UNITS*shso_pkg::STATUS_W-1:0] unitStatusFlat,
    output logic [31:0] warnFlags
);
    import shso_pkg::*;
    logic [31:0] warn_d;
    logic [31:0] warn_q;
    // one flag per unit, set while any status bit 8..15 is on
    for (genvar u = 0; u < 32; u++) begin : g_unit
        if (u < NUM_UNITS) begin : g_live
            assign warn_d[u] = |unitStatusFlat[u*STATUS_W+WARN_HI : u*STATUS_W+WARN_LO];
        end else begin : g_none
            assign warn_d[u] = 1'b0;
        end
    end
    // flags follow status, no latching
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            warn_q <= DUMMY_MASK_RST;
        end else if (clkEn) begin
            warn_q <= warn_d;
        end
    end
    assign warnFlags = warn_q;
endmodule : shso_warn

// ---- src/shso_dummy.sv ----
// answers amplifier commands locally for units marked as dummies
`timescale 1ns/1ps
module shso_dummy (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [31:0] dummyMask,
    input wire logic replyErrSel,
    input wire logic ampCmdReq,
    input wire logic [4:0] ampCmdUnit,
    output logic chainCmdReq,
    input wire logic chainAck,
    input wire logic chainErr,
    input wire logic [15:0] chainRdata,
    output logic ampReplyValid,
    output logic ampReplyErr,
    output logic [15:0] ampReplyData
);
    import shso_pkg::*;
    logic isDummy;
    logic valid_d, valid_q, err_d, err_q;
    logic [15:0] data_d, data_q;
    // unit numbers start at 1, mask bit k is unit k+1
    always_comb begin
        isDummy = 1'b0;
        if (ampCmdUnit != 5'h00) begin
            isDummy = dummyMask[ampCmdUnit - 5'h01];
        end
    end
    assign chainCmdReq = ampCmdReq && !isDummy;
    // dummy replies are zero data, normal or error per selection
    always_comb begin
        valid_d = 1'b0;
        err_d = 1'b0;
        data_d = 16'h0000;
        if (ampCmdReq && isDummy) begin
            valid_d = 1'b1;
            err_d = replyErrSel;
        end else if (chainAck) begin
            valid_d = 1'b1;
            err_d = chainErr;
            data_d = chainRdata;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            valid_q <= 1'b0;
            err_q <= 1'b0;
            data_q <= 16'h0000;
        end else if (clkEn) begin
            valid_q <= valid_d;
            err_q <= err_d;
            data_q <= data_d;
        end
    end
    assign ampReplyValid = valid_q;
    assign ampReplyErr = err_q;
    assign ampReplyData = data_q;
endmodule : shso_dummy

// ---- src/shso_top.sv ----
// status and configuration object bank of the sensor hub
// Function
// - mask bit k marks unit k+1 dummy
// - mask applies after restart, info reads active
// - dummy reply: zero data or error per setting
// - delay status byte encodes free-run delay in mapping mode 1, outside pre-operational
// - status bit 0 high while chain busy
// - status bit 1 flags sensor count mismatch
// - warning word one bit per unit
// - warning when status bits 8..15 set
// - mapping mode 0 accepts 350 bytes max
// - mapping mode 1 accepts 108 bytes max
// - mapping mode applies after restart
// - writing 0001 resets unit, reads 0000
// - bits 0..59 carry sensor outputs pairwise
// - bits 60..63 unused, read zero
`timescale 1ns/1ps
module shso_top (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic unitRestart,
    input wire logic objReq,
    input wire logic objWrite,
    input wire logic [15:0] objIndex,
    input wire logic [7:0] objSub,
    input wire logic [4:0] objUnit,
    input wire logic [31:0] objWdata,
    output logic objAck,
    output logic objErr,
    output logic [31:0] objRdata,
    input wire logic chainBusy,
    input wire logic [7:0] configuredCount,
    input wire logic [7:0] detectedCount,
    input wire logic preOperational,
    input wire logic [1:0] delaySpeed,
    input wire logic [shso_pkg::NUM_UNITS*shso_pkg::STATUS_W-1:0] unitStatusFlat,
    input wire logic [shso_pkg::NUM_UNITS-1:0] sensorOut1,
    input wire logic [shso_pkg::NUM_UNITS-1:0] sensorOut2,
    output logic [63:0] inputBits,
    input wire logic [9:0] pdoSizeReq,
    output logic pdoSizeOk,
    output logic [7:0] mapModeActive,
    input wire logic ampCmdReq,
    input wire logic [4:0] ampCmdUnit,
    output logic chainCmdReq,
    input wire logic chainAck,
    input wire logic chainErr,
    input wire logic [15:0] chainRdata,
    output logic ampReplyValid,
    output logic ampReplyErr,
    output logic [15:0] ampReplyData,
    output logic ampResetReq,
    output logic [4:0] ampResetUnit
);
    import shso_pkg::*;

    shso_state_e state_d, state_q;
    logic [31:0] maskSet_d, maskSet_q, maskAct_d, maskAct_q;
    logic [7:0] replySel_d, replySel_q;
    logic [7:0] mapSet_d, mapSet_q, mapAct_d, mapAct_q;
    logic [7:0] linkStat_d, linkStat_q, delayStat_d, delayStat_q;
    logic [63:0] inBits_d, inBits_q;
    logic [31:0] rdata_d, rdata_q;
    logic err_d, err_q;
    logic rstReq_d, rstReq_q;
    logic [4:0] rstUnit_d, rstUnit_q;
    logic [31:0] warnFlags;
    logic [63:0] mapRaw;
    logic take;

    shso_warn u_warn (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .unitStatusFlat(unitStatusFlat),
        .warnFlags(warnFlags)
    );

    // only the active mask steers replies, a pending write has no effect
    shso_dummy u_dummy (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .dummyMask(maskAct_q),
        .replyErrSel(replySel_q[0]),
        .ampCmdReq(ampCmdReq),
        .ampCmdUnit(ampCmdUnit),
        .chainCmdReq(chainCmdReq),
        .chainAck(chainAck),
        .chainErr(chainErr),
        .chainRdata(chainRdata),
        .ampReplyValid(ampReplyValid),
        .ampReplyErr(ampReplyErr),
        .ampReplyData(ampReplyData)
    );

    // sensor output pairs, spare top bits tied low
    for (genvar n = 0; n < 32; n++) begin : g_map
        if (n < NUM_UNITS) begin : g_live
            assign mapRaw[2*n] = sensorOut1[n];
            assign mapRaw[2*n+1] = sensorOut2[n];
        end else begin : g_spare
            assign mapRaw[2*n+1:2*n] = 2'b00;
        end
    end

    // one request at a time, the answer comes the cycle after it is taken
    assign take = (state_q == ST_IDLE) && objReq;

    // status bytes and settings
    always_comb begin
        maskSet_d = maskSet_q;
        maskAct_d = maskAct_q;
        replySel_d = replySel_q;
        mapSet_d = mapSet_q;
        mapAct_d = mapAct_q;
        inBits_d = mapRaw;
        linkStat_d = BYTE_RST;
        linkStat_d[LINK_BUSY_BIT] = chainBusy || rstReq_q;
        linkStat_d[LINK_MISMATCH_BIT] = configuredCount != detectedCount;
        // restart copies pending settings into force
        if (unitRestart) begin
            maskAct_d = maskSet_q;
            mapAct_d = mapSet_q;
        end
        if (preOperational) begin
            delayStat_d = DELAY_UNDEF;
        end else if (mapAct_q == MAP_NORMAL) begin
            delayStat_d = DELAY_NORMAL_MAP;
        end else begin
            case (delaySpeed)
                SPEED_STD: delayStat_d = DELAY_STD;
                SPEED_HIGH: delayStat_d = DELAY_HIGH;
                SPEED_LOW1: delayStat_d = DELAY_LOW1;
                SPEED_LOW2: delayStat_d = DELAY_LOW2;
                default: delayStat_d = DELAY_UNDEF;
            endcase
        end
        if (take && objWrite) begin
            if (objIndex == OBJ_DUMMY && objSub == SUB_ONE &&
                (objWdata & ~DUMMY_MASK_LEGAL) == 32'h00000000) begin
                maskSet_d = objWdata;
            end
            if (objIndex == OBJ_DUMMY && objSub == SUB_THREE && objWdata < 32'h00000002) begin
                replySel_d = objWdata[7:0];
            end
            if (objIndex == OBJ_MAP && objSub == SUB_ONE && objWdata < 32'h00000002) begin
                mapSet_d = objWdata[7:0];
            end
        end
    end

    // object answer and unit reset command
    always_comb begin
        state_d = state_q;
        rdata_d = rdata_q;
        err_d = err_q;
        rstReq_d = 1'b0;
        rstUnit_d = rstUnit_q;
        case (state_q)
            ST_IDLE: begin
                if (objReq) begin
                    state_d = ST_ACK;
                    rdata_d = 32'h00000000;
                    err_d = 1'b0;
                    case (objIndex)
                        OBJ_DUMMY: begin
                            if (objSub == SUB_ONE) begin
                                rdata_d = maskSet_q;
                                err_d = objWrite && (objWdata & ~DUMMY_MASK_LEGAL) != 32'h0;
                            end else if (objSub == SUB_TWO) begin
                                rdata_d = maskAct_q;
                                err_d = objWrite;
                            end else if (objSub == SUB_THREE) begin
                                rdata_d = {24'h000000, replySel_q};
                                err_d = objWrite && objWdata > 32'h00000001;
                            end else begin
                                err_d = 1'b1;
                            end
                        end
                        OBJ_DELAY: begin
                            rdata_d = {24'h000000, delayStat_q};
                            err_d = objWrite || objSub != SUB_ONE;
                        end
                        OBJ_LINK: begin
                            rdata_d = {24'h000000, linkStat_q};
                            err_d = objWrite || objSub != SUB_ONE;
                        end
                        OBJ_WARN: begin
                            rdata_d = warnFlags;
                            err_d = objWrite || objSub != SUB_ONE;
                        end
                        OBJ_MAP: begin
                            if (objSub == SUB_ONE) begin
                                rdata_d = {24'h000000, mapSet_q};
                                err_d = objWrite && objWdata > 32'h00000001;
                            end else if (objSub == SUB_TWO) begin
                                rdata_d = {24'h000000, mapAct_q};
                                err_d = objWrite;
                            end else begin
                                err_d = 1'b1;
                            end
                        end
                        OBJ_RESET: begin
                            rdata_d = {16'h0000, RESET_READ};
                            err_d = objSub != SUB_ONE;
                            // only the command value fires, anything else is dropped
                            if (objWrite && objSub == SUB_ONE && objWdata[15:0] == RESET_CMD &&
                                objUnit != 5'h00 && objUnit <= 5'(NUM_UNITS)) begin
                                rstReq_d = 1'b1;
                                rstUnit_d = objUnit;
                            end
                        end
                        OBJ_INBITS: begin
                            if (objSub == 8'h00) begin
                                rdata_d = {24'h000000, INBITS_COUNT};
                            end else if (objSub <= SUB_INBIT_LAST) begin
                                rdata_d = {31'h00000000, inBits_q[6'(objSub - 8'h01)]};
                            end
                            err_d = objWrite || objSub > SUB_INBIT_LAST;
                        end
                        default: err_d = 1'b1;
                    endcase
                end
            end
            ST_ACK: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // register every group together; clkEn low freezes all of it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            maskSet_q <= DUMMY_MASK_RST;
            maskAct_q <= DUMMY_MASK_RST;
            replySel_q <= BYTE_RST;
            mapSet_q <= MAP_NORMAL;
            mapAct_q <= MAP_NORMAL;
            linkStat_q <= BYTE_RST;
            delayStat_q <= DELAY_UNDEF;
            inBits_q <= 64'h0000000000000000;
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
            rstReq_q <= 1'b0;
            rstUnit_q <= 5'h00;
        end else if (clkEn) begin
            state_q <= state_d;
            maskSet_q <= maskSet_d;
            maskAct_q <= maskAct_d;
            replySel_q <= replySel_d;
            mapSet_q <= mapSet_d;
            mapAct_q <= mapAct_d;
            linkStat_q <= linkStat_d;
            delayStat_q <= delayStat_d;
            inBits_q <= inBits_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
            rstReq_q <= rstReq_d;
            rstUnit_q <= rstUnit_d;
        end
    end

    // size check is combinational so the assigner can probe freely
    assign pdoSizeOk = (mapAct_q == MAP_FAST) ? (pdoSizeReq <= MAP_FAST_MAX)
                                              : (pdoSizeReq <= MAP_NORMAL_MAX);
    assign objAck = state_q == ST_ACK;
    assign objErr = err_q;
    assign objRdata = rdata_q;
    assign inputBits = inBits_q;
    assign mapModeActive = mapAct_q;
    assign ampResetReq = rstReq_q;
    assign ampResetUnit = rstUnit_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    mask_restart_a: assert property (clkEn && !unitRestart |=> $stable(maskAct_q))
        else $error("active dummy mask changed without restart");
    mask_load_a: assert property (clkEn && unitRestart |=> maskAct_q == $past(maskSet_q))
        else $error("restart did not load dummy mask");
    map_restart_a: assert property (clkEn && !unitRestart |=> $stable(mapAct_q))
        else $error("active mapping mode changed without restart");
    busy_bit_a: assert property (clkEn && chainBusy |=> linkStat_q[0])
        else $error("busy bit low during chain exchange");
    mismatch_bit_a: assert property (clkEn |=> linkStat_q[1] ==
        ($past(configuredCount) != $past(detectedCount)))
        else $error("count mismatch bit wrong");
    size_fast_a: assert property (mapAct_q == MAP_FAST && pdoSizeReq > 10'h06C
        |-> !pdoSizeOk)
        else $error("oversize accepted in fast mode");
    size_norm_a: assert property (mapAct_q == MAP_NORMAL |-> pdoSizeOk ==
        (pdoSizeReq <= 10'h15E))
        else $error("normal mode size limit wrong");
    reset_read_a: assert property (objAck && $past(objIndex) == OBJ_RESET
        |-> objRdata == 32'h00000000)
        else $error("reset object read nonzero");
    reset_ignore_a: assert property (ampResetReq |-> $past(objWdata[15:0]) == 16'h0001)
        else $error("reset issued for other value");
    spare_bits_a: assert property (inputBits[63:60] == 4'h0)
        else $error("spare input bits nonzero");
    out_pair_a: assert property (clkEn |=> inputBits[3:2] == {$past(sensorOut2[1]),
        $past(sensorOut1[1])})
        else $error("unit 2 output bits misplaced");
    delay_pre_a: assert property (clkEn && preOperational |=> delayStat_q == 8'h00)
        else $error("delay status not undefined in pre-operational");
    warn_bit_a: assert property (clkEn && |unitStatusFlat[15:8] |=> warnFlags[0])
        else $error("unit 1 warning missing");
    warn_idle_a: assert property (clkEn && unitStatusFlat[15:8] == 8'h00
        |=> !warnFlags[0])
        else $error("unit 1 warning without cause");
    dummy_reply_a: assert property (clkEn && ampCmdReq && ampCmdUnit == 5'h01
        && maskAct_q[0] |=> ampReplyValid && ampReplyData == 16'h0000
        && ampReplyErr == $past(replySel_q[0]))
        else $error("dummy reply wrong");

    restart_cv: cover property (unitRestart && maskSet_q != maskAct_q);
    reset_cv: cover property (ampResetReq);
    dummy_cv: cover property (ampCmdReq && !chainCmdReq);
    mismatch_cv: cover property (linkStat_q[1]);
endmodule : shso_top

// ---- verification/shso_chain_model.sv ----
// behavioural model of the daisy-chained amplifiers answering forwarded commands
`timescale 1ns/1ps
module shso_chain_model (
    input wire logic sys_clk,
    input wire logic chainCmdReq,
    input wire logic [2:0] ansDelay,
    input wire logic ansErr,
    input wire logic [15:0] ansData,
    output logic chainAck,
    output logic chainErr,
    output logic [15:0] chainRdata
);
    logic req;
    // between answers the data lines toggle each cycle, so stale data never looks valid
    initial begin
        chainAck = 1'b0;
        chainErr = 1'b0;
        chainRdata = 16'h0000;
        forever begin
            @(posedge sys_clk);
            req = chainCmdReq;
            #2;
            // slow answers are a delay of several cycles, each line set once per step
            if (req === 1'b1) begin
                repeat (ansDelay) begin
                    chainAck = 1'b0;
                    chainErr = ~chainErr;
                    chainRdata = ~chainRdata;
                    @(posedge sys_clk);
                    #2;
                end
                chainAck = 1'b1;
                chainErr = ansErr;
                chainRdata = ansData;
            end else begin
                chainAck = 1'b0;
                chainErr = ~chainErr;
                chainRdata = ~chainRdata;
            end
        end
    end
endmodule : shso_chain_model

// ---- verification/testbench.sv ----
// self-checking bench of the sensor hub status object bank
`timescale 1ns/1ps
module testbench;
    import shso_pkg::*;
    logic sys_clk, sys_rst, clkEn, unitRestart, objReq, objWrite, objAck, objErr, chainBusy;
    logic preOperational, pdoSizeOk, ampCmdReq, chainCmdReq, chainAck, chainErr;
    logic ampReplyValid, ampReplyErr, ampResetReq, ansErr;
    logic [15:0] objIndex, chainRdata, ampReplyData, ansData, st;
    logic [7:0] objSub, configuredCount, detectedCount, mapModeActive;
    logic [4:0] objUnit, ampCmdUnit, ampResetUnit, rstUnit;
    logic [31:0] objWdata, objRdata, ew;
    logic [1:0] delaySpeed;
    logic [2:0] ansDelay;
    logic [479:0] unitStatusFlat;
    logic [29:0] sensorOut1, sensorOut2;
    logic [63:0] inputBits, eb;
    logic [9:0] pdoSizeReq;
    logic [33:0] objQ[$];
    logic [16:0] ampQ[$];
    int errors, cmp_count, rstCount, i, k;

    shso_top dut_u (.sys_clk, .sys_rst, .clkEn, .unitRestart, .objReq, .objWrite,
        .objIndex, .objSub, .objUnit, .objWdata, .objAck, .objErr, .objRdata, .chainBusy,
        .configuredCount, .detectedCount, .preOperational, .delaySpeed, .unitStatusFlat,
        .sensorOut1, .sensorOut2, .inputBits, .pdoSizeReq, .pdoSizeOk, .mapModeActive,
        .ampCmdReq, .ampCmdUnit, .chainCmdReq, .chainAck, .chainErr, .chainRdata,
        .ampReplyValid, .ampReplyErr, .ampReplyData, .ampResetReq, .ampResetUnit);
    shso_chain_model chain_u (.sys_clk, .chainCmdReq, .ansDelay, .ansErr, .ansData,
        .chainAck, .chainErr, .chainRdata);

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic final_report();
        if (errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic tick();
        @(posedge sys_clk);
        #2;
    endtask : tick

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp

    // object answers: error flag always, read data only for plain reads
    task automatic cmp_obj(input logic [33:0] note);
        cmp({objErr, note[33] ? 32'h0 : objRdata}, note[32:0]);
    endtask : cmp_obj

    // amplifier replies: error flag and sixteen data bits
    task automatic cmp_amp(input logic [16:0] note);
        cmp({ampReplyErr, ampReplyData}, note);
    endtask : cmp_amp

    task automatic expire(input logic stuck);
        if (stuck) begin
            errors++;
            $display("[FAIL] %0t no answer in time", $time);
            final_report();
        end
    endtask : expire

    // object access; data of writes and refusals is not meaningful, only the error flag
    task automatic obj(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, input logic err, input logic [31:0] rd);
        int n;
        objQ.push_back({wr | err, err, (wr | err) ? 32'h0 : rd});
        tick();
        objReq = 1'b1;
        objWrite = wr;
        objIndex = idx;
        objSub = sub;
        objWdata = wd;
        for (n = 0; n < 8 && objAck !== 1'b1; n++) tick();
        expire(n == 8);
        tick();
        objReq = 1'b0;
    endtask : obj

    task automatic amp(input logic [4:0] u, input logic err, input logic [15:0] d);
        int n;
        ampQ.push_back({err, d});
        tick();
        ampCmdReq = 1'b1;
        ampCmdUnit = u;
        tick();
        ampCmdReq = 1'b0;
        for (n = 0; n < 12 && ampQ.size() > 0; n++) tick();
        expire(n == 12);
    endtask : amp

    task automatic restart();
        tick();
        unitRestart = 1'b1;
        tick();
        unitRestart = 1'b0;
    endtask : restart

    task automatic pdo(input logic [9:0] s, input logic ok);
        tick();
        pdoSizeReq = s;
        #1;
        cmp(pdoSizeOk, ok);
    endtask : pdo

    // results are matched against the oldest note when they appear
    always @(posedge sys_clk) begin
        if (objAck === 1'b1) cmp_obj(objQ.pop_front());
        if (ampReplyValid === 1'b1) cmp_amp(ampQ.pop_front());
        if (ampResetReq === 1'b1) begin
            rstCount++;
            rstUnit = ampResetUnit;
        end
    end

    initial begin
        {unitRestart, objReq, objWrite, chainBusy, ampCmdReq, ansErr} = 6'h00;
        clkEn = 1'b1;
        {objIndex, objSub, objUnit, objWdata, ampCmdUnit, ansData} = 82'h0;
        {delaySpeed, pdoSizeReq, unitStatusFlat, sensorOut1, sensorOut2} = 552'h0;
        configuredCount = 8'h05;
        detectedCount = 8'h05;
        preOperational = 1'b1;
        ansDelay = 3'h2;
        sys_rst = 1'b1;
        void'($urandom(80));
        repeat (4) tick();
        sys_rst = 1'b0;
        obj('0, OBJ_DELAY, SUB_ONE, '0, '0, {24'h0, DELAY_UNDEF});
        obj('0, OBJ_MAP, SUB_TWO, '0, '0, 32'h0);
        obj('1, OBJ_DELAY, SUB_ONE, 32'h1, '1, 32'h0);
        preOperational = 1'b0;
        obj('0, OBJ_DELAY, SUB_ONE, '0, '0, {24'h0, DELAY_NORMAL_MAP});
        // units 1 and 3 become dummies; the count covers real plus dummy units
        obj('1, OBJ_DUMMY, SUB_ONE, 32'h5, '0, 32'h0);
        obj('1, OBJ_DUMMY, SUB_ONE, 32'h40000000, '1, 32'h0);
        obj('0, OBJ_DUMMY, SUB_ONE, '0, '0, 32'h5);
        obj('0, OBJ_DUMMY, SUB_TWO, '0, '0, 32'h0);
        ansData = 16'($urandom);
        amp(5'h1, '0, ansData);
        restart();
        obj('0, OBJ_DUMMY, SUB_TWO, '0, '0, 32'h5);
        obj('1, OBJ_DUMMY, SUB_THREE, 32'h1, '0, 32'h0);
        amp(5'h1, '1, 16'h0);
        obj('1, OBJ_DUMMY, SUB_THREE, 32'h0, '0, 32'h0);
        amp(5'h3, '0, 16'h0);
        ansErr = 1'b1;
        ansDelay = 3'h0;
        amp(5'h2, '1, ansData);
        pdo(10'h15E, 1'b1);
        pdo(10'h15F, 1'b0);
        obj('1, OBJ_MAP, SUB_ONE, 32'h2, '1, 32'h0);
        obj('1, OBJ_MAP, SUB_ONE, 32'h1, '0, 32'h0);
        obj('0, OBJ_MAP, SUB_TWO, '0, '0, 32'h0);
        pdo(10'h06D, 1'b1);
        restart();
        obj('0, OBJ_MAP, SUB_TWO, '0, '0, 32'h1);
        cmp(mapModeActive, MAP_FAST);
        pdo(10'h06C, 1'b1);
        pdo(10'h06D, 1'b0);
        for (k = 0; k < 4; k++) begin
            delaySpeed = 2'(k);
            obj('0, OBJ_DELAY, SUB_ONE, '0, '0, 32'(k + 1));
        end
        // link status reads both bits set while the chain is busy and one unit is missing
        chainBusy = 1'b1;
        detectedCount = 8'h04;
        obj('0, OBJ_LINK, SUB_ONE, '0, '0, 32'h3);
        chainBusy = 1'b0;
        detectedCount = 8'h05;
        obj('0, OBJ_LINK, SUB_ONE, '0, '0, 32'h0);
        ew = 32'h0;
        for (i = 0; i < 30; i++) begin
            st = (i % 3 == 0) ? 16'($urandom) & 16'h00FF : 16'($urandom);
            unitStatusFlat[i*16 +: 16] = st;
            ew[i] = |st[15:8];
        end
        obj('0, OBJ_WARN, SUB_ONE, '0, '0, ew);
        sensorOut1 = 30'($urandom);
        sensorOut2 = 30'($urandom);
        eb = 64'h0;
        for (i = 0; i < 30; i++) begin
            eb[2*i] = sensorOut1[i];
            eb[2*i+1] = sensorOut2[i];
        end
        tick();
        tick();
        cmp(inputBits, eb);
        // a low enable must freeze the input map although the pins move
        clkEn = 1'b0;
        sensorOut1 = ~sensorOut1;
        tick();
        tick();
        cmp(inputBits, eb);
        sensorOut1 = ~sensorOut1;
        clkEn = 1'b1;
        obj('0, OBJ_INBITS, 8'h00, '0, '0, 32'h40);
        for (k = 1; k <= 64; k++) begin
            obj('0, OBJ_INBITS, 8'(k), '0, '0, 32'(eb[k-1]));
        end
        objUnit = 5'h1E;
        obj('1, OBJ_RESET, SUB_ONE, 32'h1, '0, 32'h0);
        cmp({rstCount, rstUnit}, {32'h1, 5'h1E});
        obj('1, OBJ_RESET, SUB_ONE, 32'h2, '0, 32'h0);
        objUnit = 5'h0;
        obj('1, OBJ_RESET, SUB_ONE, 32'h1, '0, 32'h0);
        obj('0, OBJ_RESET, SUB_ONE, '0, '0, 32'h0);
        cmp(rstCount, 32'h1);
        cmp(objQ.size() + ampQ.size(), 0);
        final_report();
    end
endmodule : testbench
